// ---- dsp_pkg.sv ----
// Purpose: shared constants and types of the deflector set point serial port
// Assumes: one 100 MHz clock; link sampled synchronously
// Notes:   frame = start, 8 data lsb first, latch, 1.5 stop bits
package dsp_pkg;
  // clock and line timing
  localparam int CLK_MHZ = 100;
  localparam int LINE_MBPS = 10;
  localparam int BIT_CLKS = CLK_MHZ / LINE_MBPS;
  localparam int STOP_TENTHS = 15;
  localparam int STOP_CLKS = (BIT_CLKS * STOP_TENTHS + 9) / 10;
  localparam int FRAME_NS = 1100;
  localparam int REPLY_MAX_NS = 1500;
  localparam int REPLY_MAX_CLKS = (REPLY_MAX_NS * CLK_MHZ) / 1000;
  localparam int GAP_NS = 10000;
  localparam int GAP_CLKS = (GAP_NS * CLK_MHZ + 999) / 1000;
  // set point slew limit in Mbit/s, split into whole and fractional steps per clock
  localparam int SLEW_MBPS = 105;
  localparam int SLEW_WHOLE = SLEW_MBPS / CLK_MHZ;
  localparam int SLEW_FRAC = SLEW_MBPS % CLK_MHZ;
  // frame and position layout
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = DATA_BITS + 1;
  localparam int LATCH_POS = 8;
  localparam int POS_W = 20;
  localparam int COARSE_W = 16;
  localparam int FINE_W = 4;
  localparam int ABS_BYTES = 3;
  localparam logic [3:0] ABS_PAD = 4'h0;
  // single byte instructions
  localparam int STEP_LIMIT = 111;
  localparam logic [7:0] CMD_FETCH_ACT = 8'h70;
  localparam logic [7:0] CMD_FETCH_LO = 8'h71;
  localparam logic [7:0] CMD_FETCH_SET = 8'h73;
  localparam logic [7:0] CMD_OFF = 8'h75;
  localparam logic [7:0] CMD_ON_MODE1 = 8'h7D;
  localparam logic [7:0] CMD_ON_MODE2 = 8'h7E;
  localparam logic [7:0] REPLY_OFF = 8'h00;

  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_START = 2'b01,
    LS_DATA = 2'b11,
    LS_STOP = 2'b10
  } dsp_line_state_type;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_SEND = 2'b01,
    CS_GAP = 2'b11
  } dsp_ctl_state_type;
endpackage

// ---- dsp_link_if.sv ----
// Purpose: one axis link, half-duplex single wire between controller and device
// Assumes: idle line is high (stop level)
// Notes:   the wire level is resolved here from both output enables
interface dsp_link_if;
  logic devOut;
  logic devOe;
  logic ctlOut;
  logic ctlOe;
  logic line;

  assign line = devOe ? devOut : (ctlOe ? ctlOut : 1'b1);

  modport device (input line, output devOut, output devOe);
  modport controller (input line, output ctlOut, output ctlOe);
endinterface

// ---- dsp_frame_phy.sv ----
// Purpose: frame transmitter and receiver for one half-duplex axis link
// Assumes: lineIn synchronous to clock
// Notes:   receiver is blind while transmitting, so own frames never echo back
module dsp_frame_phy
  import dsp_pkg::*;
#(
  parameter int BIT_CYC = BIT_CLKS,
  parameter int STOP_CYC = STOP_CLKS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOe,
  input wire logic txValid,
  output logic txReady,
  input wire logic [FRAME_BITS-1:0] txData,
  output logic rxValid,
  output logic [FRAME_BITS-1:0] rxData
);
  if (BIT_CYC < 4 || BIT_CYC > 31 || STOP_CYC < BIT_CYC || STOP_CYC > 31
      || BIT_CYC - BIT_CYC / 2 + STOP_CYC > 34) begin : g_chk
    $error("dsp_frame_phy: bit or stop length out of range");
  end

  typedef struct packed {
    dsp_line_state_type rxSt;
    logic [4:0] rxCnt;
    logic [3:0] rxIdx;
    logic [FRAME_BITS-1:0] rxSh;
    logic rxValid;
    logic [FRAME_BITS-1:0] rxData;
    dsp_line_state_type txSt;
    logic [4:0] txCnt;
    logic [3:0] txIdx;
    logic [FRAME_BITS-1:0] txSh;
    logic txOut;
    logic txOe;
  } dsp_phy_type;

  dsp_phy_type state_r, state_nxt;

  // one party at a time: no new frame while one is being received
  assign txReady = (state_r.txSt == LS_IDLE) && (state_r.rxSt == LS_IDLE);
  assign lineOut = state_r.txOut;
  assign lineOe = state_r.txOe;
  assign rxValid = state_r.rxValid;
  assign rxData = state_r.rxData;

  always_comb begin
    state_nxt = state_r;
    state_nxt.rxValid = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // RULE4 receive order
    case (state_r.rxSt)
      LS_IDLE: begin
        if (state_r.txSt == LS_IDLE && !lineIn) begin
          state_nxt.rxSt = LS_START;
          state_nxt.rxCnt = 5'(BIT_CYC / 2 - 1);
        end
      end
      LS_START: begin
        if (state_r.rxCnt == 5'h00) begin
          // a start bit gone high by mid bit was only a glitch
          state_nxt.rxSt = lineIn ? LS_IDLE : LS_DATA;
          state_nxt.rxCnt = 5'(BIT_CYC - 1);
          state_nxt.rxIdx = 4'h0;
        end else begin
          state_nxt.rxCnt = state_r.rxCnt - 5'h01;
        end
      end
      LS_DATA: begin
        if (state_r.rxCnt == 5'h00) begin
          state_nxt.rxSh = {lineIn, state_r.rxSh[FRAME_BITS-1:1]};
          state_nxt.rxCnt = 5'(BIT_CYC - 1);
          state_nxt.rxIdx = state_r.rxIdx + 4'h1;
          if (state_r.rxIdx == 4'(FRAME_BITS - 1)) begin
            state_nxt.rxSt = LS_STOP;
            // stop judged one cycle before its end, so a reply never overlaps the sender's stop
            state_nxt.rxCnt = 5'(BIT_CYC - BIT_CYC / 2 + STOP_CYC - 3);
          end
        end else begin
          state_nxt.rxCnt = state_r.rxCnt - 5'h01;
        end
      end
      LS_STOP: begin
        if (state_r.rxCnt == 5'h00) begin
          state_nxt.rxSt = LS_IDLE;
          // RULE16 bad stop dropped
          if (lineIn) begin
            state_nxt.rxValid = 1'b1;
            state_nxt.rxData = state_r.rxSh;
          end
        end else begin
          state_nxt.rxCnt = state_r.rxCnt - 5'h01;
        end
      end
      default: state_nxt.rxSt = LS_IDLE;
    endcase
    ////////////////////////////////////////////////////////////////////////
    // RULE1 bit timing
    case (state_r.txSt)
      LS_IDLE: begin
        state_nxt.txOe = 1'b0;
        state_nxt.txOut = 1'b1;
        if (txValid && txReady) begin
          state_nxt.txSt = LS_START;
          state_nxt.txOut = 1'b0;
          state_nxt.txOe = 1'b1;
          state_nxt.txCnt = 5'(BIT_CYC - 1);
          state_nxt.txSh = txData;
        end
      end
      LS_START: begin
        if (state_r.txCnt == 5'h00) begin
          state_nxt.txSt = LS_DATA;
          state_nxt.txOut = state_r.txSh[0];
          state_nxt.txSh = state_r.txSh >> 1;
          state_nxt.txIdx = 4'h0;
          state_nxt.txCnt = 5'(BIT_CYC - 1);
        end else begin
          state_nxt.txCnt = state_r.txCnt - 5'h01;
        end
      end
      LS_DATA: begin
        if (state_r.txCnt == 5'h00) begin
          if (state_r.txIdx == 4'(FRAME_BITS - 1)) begin
            // RULE2 stop of 1.5 bits
            state_nxt.txSt = LS_STOP;
            state_nxt.txOut = 1'b1;
            state_nxt.txCnt = 5'(STOP_CYC - 1);
          end else begin
            state_nxt.txOut = state_r.txSh[0];
            state_nxt.txSh = state_r.txSh >> 1;
            state_nxt.txIdx = state_r.txIdx + 4'h1;
            state_nxt.txCnt = 5'(BIT_CYC - 1);
          end
        end else begin
          state_nxt.txCnt = state_r.txCnt - 5'h01;
        end
      end
      LS_STOP: begin
        if (state_r.txCnt == 5'h00) begin
          // RULE3 release line
          state_nxt.txSt = LS_IDLE;
          state_nxt.txOe = 1'b0;
        end else begin
          state_nxt.txCnt = state_r.txCnt - 5'h01;
        end
      end
      default: state_nxt.txSt = LS_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '{rxSt: LS_IDLE, txSt: LS_IDLE, txOut: 1'b1, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule

// ---- dsp_device.sv ----
// Summary of operation
// RULE1 - 10 Mbit/s, eight data bits plus latch
// RULE2 - stop level held one and a half bits
// RULE3 - half-duplex, a frame takes about 1.1 us
// RULE4 - start, data lsb first, latch, stop
// RULE5 - instruction acted on only at latch byte
// RULE6 - controller sets latch only on last byte
// RULE7 - device replies always with latch cleared
// RULE8 - reply starts within 1.5 us
// RULE9 - controller spaces instruction starts by 10 us
// RULE10 - set point and actual are 20-bit signed
// RULE11 - absolute target is three bytes, no reply
// RULE12 - byte instructions use upper 16 bits, one reply
// RULE13 - set point slews toward target at 105 Mbit/s
// RULE14 - two independent links, horizontal and vertical
// RULE15 - absolute bytes carry bits 0-3, 4-11, 12-19
// RULE16 - frame with low stop bit is discarded
//
// Purpose: device end, one instruction engine per axis
// Assumes: actual positions come from the regulator synchronous to clock
// Notes:   relative steps bypass the slew limiter, only absolute targets slew

////////////////////////////////////////////////////////////////////////////
module dsp_device_axis
  import dsp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  dsp_link_if.device link,
  input wire logic [POS_W-1:0] actualPos,
  output logic [POS_W-1:0] setPoint,
  output logic [POS_W-1:0] targetPos,
  output logic axisOn,
  output logic echoMode
);
  typedef struct packed {
    logic [POS_W-1:0] setPt;
    logic [POS_W-1:0] target;
    logic [6:0] fracAcc;
    logic [1:0] byteCnt;
    logic [7:0] first;
    logic [7:0] second;
    logic on;
    logic mode2;
    logic [COARSE_W-1:0] lastAct;
    logic [7:0] fetchLo;
    logic txReq;
    logic [7:0] txByte;
  } dsp_axis_type;

  dsp_axis_type state_r, state_nxt;
  logic txReady;
  logic rxValid;
  logic [FRAME_BITS-1:0] rxData;
  logic [FRAME_BITS-1:0] txData;
  logic signed [POS_W:0] diff;
  logic signed [POS_W:0] allow;
  logic [7:0] fracSum;
  logic [7:0] cmd;
  logic [POS_W-1:0] stepExt;
  logic [COARSE_W-1:0] delta;

  // RULE7 reply latch clear
  assign txData = {1'b0, state_r.txByte};

  dsp_frame_phy u_phy (
    .clock(clock),
    .rst_n(rst_n),
    .lineIn(link.line),
    .lineOut(link.devOut),
    .lineOe(link.devOe),
    .txValid(state_r.txReq),
    .txReady(txReady),
    .txData(txData),
    .rxValid(rxValid),
    .rxData(rxData)
  );

  // RULE10 20-bit positions
  assign setPoint = state_r.setPt;
  assign targetPos = state_r.target;
  assign axisOn = state_r.on;
  assign echoMode = state_r.mode2;

  always_comb begin
    state_nxt = state_r;
    cmd = rxData[7:0];
    stepExt = {{(POS_W-FINE_W-8){cmd[7]}}, cmd, ABS_PAD};
    delta = actualPos[POS_W-1:FINE_W] - state_r.lastAct;
    fracSum = {1'b0, state_r.fracAcc} + 8'(SLEW_FRAC);
    diff = $signed({state_r.target[POS_W-1], state_r.target}) - $signed({state_r.setPt[POS_W-1], state_r.setPt});
    //////////////////////////////////////////////////////////////////////
    // RULE13 slew limit
    // fractional accumulator keeps the long-run rate exact at 105 per 100 clocks
    if (fracSum >= 8'(CLK_MHZ)) begin
      allow = (POS_W+1)'(SLEW_WHOLE + 1);
      state_nxt.fracAcc = 7'(fracSum - 8'(CLK_MHZ));
    end else begin
      allow = (POS_W+1)'(SLEW_WHOLE);
      state_nxt.fracAcc = fracSum[6:0];
    end
    if (diff > allow) begin
      state_nxt.setPt = state_r.setPt + allow[POS_W-1:0];
    end else if (diff < -allow) begin
      state_nxt.setPt = state_r.setPt - allow[POS_W-1:0];
    end else begin
      state_nxt.setPt = state_r.target;
    end
    //////////////////////////////////////////////////////////////////////
    // RULE8 reply handshake
    // request is taken the cycle after the latch byte, far inside 1.5 us
    if (state_r.txReq && txReady) begin
      state_nxt.txReq = 1'b0;
    end
    //////////////////////////////////////////////////////////////////////
    if (rxValid) begin
      if (!rxData[LATCH_POS]) begin
        // RULE5 collect only
        case (state_r.byteCnt)
          2'h0: state_nxt.first = cmd;
          2'h1: state_nxt.second = cmd;
          default: state_nxt.first = state_r.first;
        endcase
        // saturates at 3 so an overlong run is thrown away at its latch
        if (state_r.byteCnt != 2'h3) begin
          state_nxt.byteCnt = state_r.byteCnt + 2'h1;
        end
      end else begin
        state_nxt.byteCnt = 2'h0;
        if (state_r.byteCnt == 2'(ABS_BYTES - 1)) begin
          // RULE11 absolute target
          // RULE15 byte layout
          state_nxt.target = {cmd, state_r.second, state_r.first[7:FINE_W]};
        end else if (state_r.byteCnt == 2'h0) begin
          // RULE12 byte instruction
          if ($signed(cmd) >= -STEP_LIMIT && $signed(cmd) <= STEP_LIMIT) begin
            // a switched off axis neither moves nor replies on a relative step
            if (state_r.on) begin
              state_nxt.setPt = state_nxt.setPt + stepExt;
              state_nxt.target = state_r.target + stepExt;
              state_nxt.txReq = 1'b1;
              if (state_r.mode2) begin
                state_nxt.txByte = cmd;
              end else begin
                state_nxt.txByte = delta[7:0];
                state_nxt.lastAct = actualPos[POS_W-1:FINE_W];
              end
            end
          end else begin
            case (cmd)
              CMD_FETCH_ACT: begin
                state_nxt.txReq = 1'b1;
                state_nxt.txByte = actualPos[POS_W-1:POS_W-8];
                state_nxt.fetchLo = actualPos[POS_W-9:FINE_W];
                state_nxt.lastAct = actualPos[POS_W-1:FINE_W];
              end
              CMD_FETCH_SET: begin
                state_nxt.txReq = 1'b1;
                state_nxt.txByte = state_r.setPt[POS_W-1:POS_W-8];
                state_nxt.fetchLo = state_r.setPt[POS_W-9:FINE_W];
              end
              CMD_FETCH_LO: begin
                state_nxt.txReq = 1'b1;
                state_nxt.txByte = state_r.fetchLo;
              end
              CMD_OFF: begin
                state_nxt.on = 1'b0;
                state_nxt.txReq = 1'b1;
                state_nxt.txByte = REPLY_OFF;
              end
              CMD_ON_MODE1, CMD_ON_MODE2: begin
                state_nxt.on = 1'b1;
                state_nxt.mode2 = (cmd == CMD_ON_MODE2);
                state_nxt.txReq = 1'b1;
                state_nxt.txByte = cmd;
              end
              default: state_nxt.txReq = state_nxt.txReq;
            endcase
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module dsp_device
  import dsp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  dsp_link_if.device horizontalLink,
  dsp_link_if.device verticalLink,
  input wire logic [POS_W-1:0] horizontalActual,
  input wire logic [POS_W-1:0] verticalActual,
  output logic [POS_W-1:0] horizontalSetPoint,
  output logic [POS_W-1:0] verticalSetPoint,
  output logic [POS_W-1:0] horizontalTarget,
  output logic [POS_W-1:0] verticalTarget,
  output logic horizontalOn,
  output logic verticalOn,
  output logic horizontalEcho,
  output logic verticalEcho
);
  // RULE14 horizontal channel
  dsp_device_axis u_horizontal_axis_channel (
    .clock(clock),
    .rst_n(rst_n),
    .link(horizontalLink),
    .actualPos(horizontalActual),
    .setPoint(horizontalSetPoint),
    .targetPos(horizontalTarget),
    .axisOn(horizontalOn),
    .echoMode(horizontalEcho)
  );

  // RULE14 vertical channel
  dsp_device_axis u_vertical_axis_channel (
    .clock(clock),
    .rst_n(rst_n),
    .link(verticalLink),
    .actualPos(verticalActual),
    .setPoint(verticalSetPoint),
    .targetPos(verticalTarget),
    .axisOn(verticalOn),
    .echoMode(verticalEcho)
  );
endmodule

// ---- dsp_controller.sv ----
// Purpose: controller end of one axis link
// Assumes: user holds command fields stable while cmdValid and not cmdReady
// Notes:   one instruction per 10 us window; a reply inside the window is reported
module dsp_controller
  import dsp_pkg::*;
#(
  parameter int GAP_CYC = GAP_CLKS
) (
  input wire logic clock,
  input wire logic rst_n,
  dsp_link_if.controller link,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdAbs,
  input wire logic [POS_W-1:0] cmdTarget,
  input wire logic [7:0] cmdByte,
  output logic replyValid,
  output logic [7:0] replyData
);
  localparam int GAP_W = $clog2(GAP_CYC + 1);

  if (GAP_CYC < 2 * ABS_BYTES * (BIT_CLKS * 10 + STOP_CLKS)) begin : g_chk
    $error("dsp_controller: gap shorter than an absolute instruction");
  end

  typedef struct packed {
    dsp_ctl_state_type st;
    logic [1:0] left;
    logic [8*ABS_BYTES-1:0] queue;
    logic [GAP_W-1:0] gapCnt;
    logic replyValid;
    logic [7:0] replyData;
  } dsp_ctl_type;

  dsp_ctl_type state_r, state_nxt;
  logic txReady;
  logic rxValid;
  logic [FRAME_BITS-1:0] rxData;
  logic [FRAME_BITS-1:0] txData;

  // RULE6 latch on last byte
  assign txData = {state_r.left == 2'h1, state_r.queue[7:0]};
  assign cmdReady = (state_r.st == CS_IDLE);
  assign replyValid = state_r.replyValid;
  assign replyData = state_r.replyData;

  dsp_frame_phy u_phy (
    .clock(clock),
    .rst_n(rst_n),
    .lineIn(link.line),
    .lineOut(link.ctlOut),
    .lineOe(link.ctlOe),
    .txValid(state_r.st == CS_SEND),
    .txReady(txReady),
    .txData(txData),
    .rxValid(rxValid),
    .rxData(rxData)
  );

  always_comb begin
    state_nxt = state_r;
    state_nxt.replyValid = rxValid;
    if (rxValid) begin
      state_nxt.replyData = rxData[7:0];
    end
    if (state_r.gapCnt != '0) begin
      state_nxt.gapCnt = state_r.gapCnt - GAP_W'(1);
    end
    case (state_r.st)
      CS_IDLE: begin
        if (cmdValid) begin
          state_nxt.st = CS_SEND;
          // RULE9 instruction spacing
          state_nxt.gapCnt = GAP_W'(GAP_CYC - 1);
          if (cmdAbs) begin
            // RULE15 byte layout
            state_nxt.queue = {cmdTarget[POS_W-1:12], cmdTarget[11:FINE_W], cmdTarget[FINE_W-1:0], ABS_PAD};
            state_nxt.left = 2'(ABS_BYTES);
          end else begin
            state_nxt.queue = {16'h0000, cmdByte};
            state_nxt.left = 2'h1;
          end
        end
      end
      CS_SEND: begin
        if (txReady) begin
          state_nxt.queue = state_r.queue >> 8;
          state_nxt.left = state_r.left - 2'h1;
          if (state_r.left == 2'h1) begin
            state_nxt.st = CS_GAP;
          end
        end
      end
      CS_GAP: begin
        if (state_r.gapCnt == '0) begin
          state_nxt.st = CS_IDLE;
        end
      end
      default: state_nxt.st = CS_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '{st: CS_IDLE, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule

// ---- dsp_link_assertions.sv ----
// Purpose: wire checks on the horizontal axis link
// Assumes: both link ends are design code on one clock
// Notes:   counters measure frame length, stop run and turnaround time
module dsp_link_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic devOut,
  input wire logic devOe,
  input wire logic ctlOut,
  input wire logic ctlOe,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] devCnt_r;
  logic [7:0] ctlCnt_r;
  logic [7:0] devHi_r;
  logic [7:0] endCnt_r;
  logic latch_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

////////////////////////////////////////
  // turnaround count saturates so an idle link never wraps into a false pass
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      devCnt_r <= 8'h00;
      ctlCnt_r <= 8'h00;
      devHi_r <= 8'h00;
      endCnt_r <= 8'h00;
      latch_r <= 1'h0;
    end else begin
      devCnt_r <= devOe ? devCnt_r + 8'h01 : 8'h00;
      ctlCnt_r <= ctlOe ? ctlCnt_r + 8'h01 : 8'h00;
      devHi_r <= (devOe && devOut) ? devHi_r + 8'h01 : 8'h00;
      endCnt_r <= ctlOe ? 8'h00 : ((endCnt_r == 8'hFF) ? 8'hFF : endCnt_r + 8'h01);
      if (ctlCnt_r == 8'h5F) begin
        latch_r <= ctlOut;
      end
    end
  end

////////////////////////////////////////
  sequence s_dev_start;
    (!line) [*8];
  endsequence
  sequence s_ctl_start;
    (!ctlOut) [*8];
  endsequence
  sequence s_next_byte;
    ##[1:300] $rose(ctlOe);
  endsequence

  property p_dev_len;
    $fell(devOe) |-> devCnt_r == 8'h73;
  endproperty
  property p_ctl_len;
    $fell(ctlOe) |-> ctlCnt_r == 8'h73;
  endproperty
  property p_dev_start;
    $rose(devOe) |-> s_dev_start;
  endproperty
  property p_ctl_start;
    $rose(ctlOe) |-> s_ctl_start;
  endproperty
  property p_dev_stop;
    $fell(devOe) |-> devHi_r == 8'h0F;
  endproperty
  property p_dev_latch;
    devOe && devCnt_r == 8'h5F |-> !devOut;
  endproperty
  property p_reply_time;
    $rose(devOe) |-> endCnt_r <= 8'h96;
  endproperty
  property p_no_act;
    $fell(ctlOe) && !latch_r |-> !devOe throughout s_next_byte;
  endproperty
  property p_half_duplex;
    !(devOe && ctlOe);
  endproperty

  a_dev_len: assert property (p_dev_len) // frame length
    else $error("device frame length wrong");
  a_ctl_len: assert property (p_ctl_len) // frame length
    else $error("controller frame length wrong");
  a_dev_start: assert property (p_dev_start) // start low
    else $error("device start bit not low");
  a_ctl_start: assert property (p_ctl_start) // start low
    else $error("controller start bit not low");
  a_dev_stop: assert property (p_dev_stop) // stop length
    else $error("device stop run wrong");
  a_dev_latch: assert property (p_dev_latch) // reply latch
    else $error("device reply latch set");
  a_reply_time: assert property (p_reply_time) // turnaround bound
    else $error("device reply too late");
  a_no_act: assert property (p_no_act) // collect only
    else $error("device acted on unlatched byte");
  a_half_duplex: assert property (p_half_duplex) // one talker
    else $error("both ends drive the link");
endmodule

// ---- deflector_setpoint_serial_port_tb_top.sv ----
// Purpose: drives both axes of the serial port end to end
// Assumes: horizontal via the controller, vertical bit by bit from here
// Notes:   vertical side also injects a frame with a low stop bit
module deflector_setpoint_serial_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock;
  logic rst_n;
  logic cmdValid;
  logic cmdAbs;
  logic cmdReady;
  logic replyValid;
  logic [19:0] cmdTarget;
  logic [19:0] hAct;
  logic [19:0] vAct;
  logic [19:0] hSp;
  logic [19:0] vSp;
  logic [19:0] hTg;
  logic [19:0] vTg;
  logic [19:0] sp;
  logic [7:0] cmdByte;
  logic [7:0] replyData;
  logic hOn;
  logic vOn;
  logic hEcho;
  logic vEcho;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;

  dsp_link_if hIf();
  dsp_link_if vIf();

  dsp_device u_dsp_device (.clock(clock), .rst_n(rst_n), .horizontalLink(hIf.device),
    .verticalLink(vIf.device), .horizontalActual(hAct), .verticalActual(vAct),
    .horizontalSetPoint(hSp), .verticalSetPoint(vSp), .horizontalTarget(hTg), .verticalTarget(vTg),
    .horizontalOn(hOn), .verticalOn(vOn), .horizontalEcho(hEcho), .verticalEcho(vEcho));
  dsp_controller u_dsp_controller (.clock(clock), .rst_n(rst_n), .link(hIf.controller),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdAbs(cmdAbs), .cmdTarget(cmdTarget),
    .cmdByte(cmdByte), .replyValid(replyValid), .replyData(replyData));
  dsp_link_assertions u_dsp_link_assertions (.clock(clock), .rst_n(rst_n), .devOut(hIf.devOut),
    .devOe(hIf.devOe), .ctlOut(hIf.ctlOut), .ctlOe(hIf.ctlOe), .line(hIf.line));

////////////////////////////////////////
  always #5 clock = ~clock;

  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("BAD at %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // every input change lands 1 ns after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic hCmd(input logic ab, input logic [19:0] val, input logic rep, input logic [7:0] want);
    logic got;
    got = 1'h0;
    while (cmdReady !== 1'h1) tick(1);
    cmdAbs = ab;
    cmdTarget = val;
    cmdByte = val[7:0];
    cmdValid = 1'h1;
    tick(1);
    cmdValid = 1'h0;
    while (cmdReady !== 1'h1) begin
      if (replyValid === 1'h1) begin
        got = 1'h1;
        check(20'(replyData), 20'(want));
      end
      tick(1);
    end
    check(20'(got), 20'(rep));
  endtask

  // d holds latch then data; stp is the level driven for the stop period
  task automatic vFrame(input logic [8:0] d, input logic stp);
    logic [10:0] f;
    f = {stp, d, 1'h0};
    vIf.ctlOe = 1'h1;
    for (int i = 0; i < 11; i++) begin
      vIf.ctlOut = f[i];
      tick((i == 10) ? 15 : 10);
    end
    vIf.ctlOe = 1'h0;
  endtask

  // samples bit centres from the edge the device takes the wire
  task automatic vRecv(input logic [7:0] want);
    logic [10:0] r;
    int n;
    n = 0;
    while (vIf.devOe !== 1'h1 && n < 300) begin
      tick(1);
      n++;
    end
    check(20'(n < 266), 20'h00001); // reply start
    for (int k = 0; k < 11; k++) begin
      tick((k == 0) ? 5 : 10);
      r[k] = vIf.line;
    end
    check(20'(r), {9'h000, 1'h1, 1'h0, want, 1'h0}); // wire order
  endtask

////////////////////////////////////////
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    clock = 1'h0;
    rst_n = 1'h0;
    cmdValid = 1'h0;
    cmdAbs = 1'h0;
    cmdTarget = 20'h00000;
    cmdByte = 8'h00;
    hAct = 20'h12340;
    vAct = 20'h00000;
    vIf.ctlOe = 1'h0;
    vIf.ctlOut = 1'h1;
    tick(6);
    rst_n = 1'h1;
    fork
      vFrame({1'h1, 8'h7D}, 1'h1);
      vRecv(8'h7D);
    join
    check(20'({vOn, hOn}), 20'h00002); // axes apart
    check(20'(vEcho), 20'h00000); // vertical mode one
    tick(1000); // instruction spacing
    vFrame({1'h0, 8'h40}, 1'h1);
    vFrame({1'h0, 8'h55}, 1'h0);
    tick(3);
    vFrame({1'h0, 8'h3A}, 1'h1);
    check(vTg, 20'h00000); // not yet latched
    vFrame({1'h1, 8'h00}, 1'h1);
    tick(2);
    check(vTg, 20'h003A4); // bad frame dropped
    sp = vSp;
    tick(100);
    check(20'((vSp - sp) <= 20'h00069 && (vSp - sp) >= 20'h00064), 20'h00001); // slew rate
    tick(1000);
    check(vSp, 20'h003A4); // target reached
    check(hTg, 20'h00000); // other axis untouched
    hCmd(1'h0, 20'h00003, 1'h0, 8'h00); // off ignores steps
    hCmd(1'h0, 20'h0007D, 1'h1, 8'h7D); // mode one
    check(20'({hOn, hEcho}), 20'h00002); // on state
    hCmd(1'h0, 20'h00070, 1'h1, 8'h12); // fetch actual
    hCmd(1'h0, 20'h00071, 1'h1, 8'h34); // low byte
    hAct = 20'h12390;
    hCmd(1'h0, 20'h00003, 1'h1, 8'h05); // delta actual
    check(hSp, 20'h00030); // step scaled
    hCmd(1'h0, 20'h0007E, 1'h1, 8'h7E); // mode two
    hCmd(1'h0, 20'h00091, 1'h1, 8'h91); // echo of lowest step
    check(hSp, 20'hFF940); // signed wrap
    hCmd(1'h0, 20'h00073, 1'h1, 8'hFF); // fetch set point
    hCmd(1'h0, 20'h00071, 1'h1, 8'h94); // low byte
    hCmd(1'h1, 20'hFFB57, 1'h0, 8'h00); // no reply
    check(hTg, 20'hFFB57); // target bits
    check(hSp, 20'hFFB57); // slew settles
    hCmd(1'h0, 20'h00073, 1'h1, 8'hFF); // upper byte
    hCmd(1'h0, 20'h00071, 1'h1, 8'hB5); // fine bits dropped
    hCmd(1'h0, 20'h0007F, 1'h0, 8'h00); // unknown code silent
    hCmd(1'h0, 20'h00075, 1'h1, 8'h00); // switch off
    hCmd(1'h0, 20'h00002, 1'h0, 8'h00); // off is silent
    check(hSp, 20'hFFB57); // no move when off
    check(vSp, 20'h003A4); // other axis untouched
    conclude();
  end
endmodule
